// ### design/mide_pkg.sv
// shared constants and types of the instruction decode and execute block
package mide_pkg;
  localparam int PC_W = 13;
  localparam int STK_DEPTH = 8;
  localparam int FILE_DEPTH = 128;
  localparam int SP_W = 3;
  // file register addresses the core itself interprets
  localparam logic [6:0] ADDR_TIMER_ZERO_COUNT = 7'h01;
  localparam logic [6:0] ADDR_STATUS = 7'h03;
  localparam logic [6:0] ADDR_IO_PORT_B = 7'h06;
  // status register bit positions and reset value
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  localparam int ST_PD = 3;
  localparam int ST_TO = 4;
  localparam logic [7:0] STATUS_RST = 8'h18;
  // fixed control words and masks
  localparam logic [13:0] W_RETURN = 14'h0008;
  localparam logic [13:0] W_INTERRUPT_RETURN = 14'h0009;
  localparam logic [13:0] W_SLEEP = 14'h0063;
  localparam logic [13:0] W_WDTKICK = 14'h0064;
  localparam logic [13:0] NOP_MASK = 14'h3F9F;
  localparam logic [13:0] NOP_VAL = 14'h0000;
  // register bus map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATE = 8'h04;
  localparam logic [7:0] REG_FLAGS = 8'h08;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PSA = 1;
  localparam int CTRL_WAKE = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MIDE_Q1, MIDE_Q2, MIDE_Q3, MIDE_Q4} mide_phase_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [7:0]  araddr;
  } mide_axi_req_t;

  typedef struct packed {
    logic [1:0]  bresp;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mide_axi_rsp_t;
endpackage : mide_pkg

// ### design/mide_core.sv
// instruction decode and execute core with its register bus slave
// Behaviour
// - byte ops write result to accumulator when d is 0, else to file register
// - one instruction cycle is four clock periods; plain ops finish in one
// - seven bit file field reaches every file location 0x00 to 0x7F
// - rotate left through carry, carry into bit 0, only carry changes
// - rotate right through carry, stored per d, only carry changes
// - decrement, store per d, no flags, skip next when result is zero
// - increment, store per d, no flags, skip next when result is zero
// - OR accumulator with file, store per d, only zero flag
// - OR literal into accumulator, only zero flag, one cycle
// - XOR literal into accumulator, only zero flag
// - literal minus accumulator into accumulator, updates carry, digit carry, zero
// - literal plus accumulator into accumulator, updates carry, digit carry, zero
// - AND literal into accumulator, only zero flag
// - skip next when selected bit is clear, two cycles then, no flags
// - skip next when selected bit is set, second cycle on skip
// - subroutine return loads counter from stack top, two cycles
// - interrupt return pops counter, two cycles
// - load literal into accumulator and return, two cycles
// - standby word enters sleep, sets expiry flag, clears powerdown flag
// - watchdog kick clears watchdog, sets expiry and powerdown flags
// - port register operands come from pin levels, not the latch
// - writes to timer register clear prescaler when assigned to it
// - counter change or true test costs an idle second cycle
`timescale 1ns/10ps
`default_nettype none
module mide_core (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset_n,
  // program memory
  output logic [mide_pkg::PC_W-1:0] imem_addr,
  input  wire logic [13:0]          imem_data,
  // port b pins and side effects
  input  wire logic [7:0]           port_b_pins,
  output logic [7:0]                port_b_latch,
  output logic                      wdt_clear,
  output logic                      psc_clear,
  output logic                      sleeping,
  // register bus
  input  wire logic                 s_awvalid,
  output logic                      s_awready,
  input  wire logic                 s_wvalid,
  output logic                      s_wready,
  output logic                      s_bvalid,
  input  wire logic                 s_bready,
  input  wire logic                 s_arvalid,
  output logic                      s_arready,
  output logic                      s_rvalid,
  input  wire logic                 s_rready,
  input  wire mide_pkg::mide_axi_req_t s_req,
  output mide_pkg::mide_axi_rsp_t   s_rsp
);
  import mide_pkg::*;

  typedef struct packed {
    mide_phase_t                      ph;
    logic [PC_W-1:0]                  pc;
    logic [7:0]                       w;
    logic [FILE_DEPTH-1:0][7:0]       mem;
    logic [STK_DEPTH-1:0][PC_W-1:0]   stk;
    logic [SP_W-1:0]                  sp;
    logic                             flush;
    logic                             sleep;
    logic                             gie;
    logic                             wdt_clr;
    logic                             psc_clr;
    logic [7:0]                       pin_s1;
    logic [7:0]                       pin_s2;
    logic                             run;
    logic                             psa;
    logic                             awready;
    logic                             wready;
    logic                             bvalid;
    logic                             arready;
    logic                             rvalid;
    mide_axi_rsp_t                    rsp;
  } mide_state_t;

  mide_state_t s_q;
  mide_state_t s_d;

  // sum with nibble carry: {dc, c, sum}
  function automatic logic [9:0] mide_add(input logic [7:0] a, input logic [7:0] b, input logic cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    return {low[4], full};
  endfunction : mide_add

  logic [13:0] ins;
  logic [6:0]  fa;
  logic [7:0]  k;
  logic [2:0]  bsel;
  logic        dbit;
  logic [7:0]  fval;
  logic [7:0]  res;
  logic [9:0]  alu;
  logic        exec;
  logic        wr_w;
  logic        wr_f;
  logic        upd_z;
  logic        upd_c;
  logic        upd_dc;
  logic        skip;
  logic        jump;
  logic [PC_W-1:0] jtgt;
  logic [7:0]  st;
  logic        aw_hit;
  logic        ar_hit;

  assign ins = imem_data;
  assign fa = ins[6:0];
  assign k = ins[7:0];
  assign bsel = ins[9:7];
  assign dbit = ins[7];

  always_comb begin
    s_d = s_q;
    s_d.pin_s1 = port_b_pins;
    s_d.pin_s2 = s_q.pin_s1;
    s_d.wdt_clr = 1'b0;
    s_d.psc_clr = 1'b0;
    // one instruction slot spans four clock phases
    case (s_q.ph)
      MIDE_Q1: s_d.ph = MIDE_Q2;
      MIDE_Q2: s_d.ph = MIDE_Q3;
      MIDE_Q3: s_d.ph = MIDE_Q4;
      MIDE_Q4: s_d.ph = MIDE_Q1;
      default: s_d.ph = MIDE_Q1;
    endcase
    exec = (s_q.ph == MIDE_Q4) && s_q.run && !s_q.sleep && !s_q.flush;
    // port reads see the pins so read-modify-write keeps external levels
    fval = (fa == ADDR_IO_PORT_B) ? s_q.pin_s2 : s_q.mem[fa];
    res = 8'h00;
    alu = 10'h000;
    wr_w = 1'b0;
    wr_f = 1'b0;
    upd_z = 1'b0;
    upd_c = 1'b0;
    upd_dc = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    jtgt = s_q.pc + 13'h0001;
    st = s_q.mem[ADDR_STATUS];
    case (ins[13:12])
      2'b00: begin
        case (ins[11:8])
          4'h0: begin
            if (dbit) begin
              res = s_q.w;
              wr_f = 1'b1;
            end
          end
          4'h1: begin
            res = 8'h00;
            upd_z = 1'b1;
            wr_f = dbit;
            wr_w = !dbit;
          end
          4'h2: begin
            alu = mide_add(fval, ~s_q.w, 1'b1);
            res = alu[7:0];
            {upd_c, upd_dc, upd_z} = 3'b111;
          end
          4'h3: begin
            res = fval - 8'h01;
            upd_z = 1'b1;
          end
          4'h4: begin
            res = s_q.w | fval;
            upd_z = 1'b1;
          end
          4'h5: begin
            res = s_q.w & fval;
            upd_z = 1'b1;
          end
          4'h6: begin
            res = s_q.w ^ fval;
            upd_z = 1'b1;
          end
          4'h7: begin
            alu = mide_add(fval, s_q.w, 1'b0);
            res = alu[7:0];
            {upd_c, upd_dc, upd_z} = 3'b111;
          end
          4'h8: begin
            res = fval;
            upd_z = 1'b1;
          end
          4'h9: begin
            res = ~fval;
            upd_z = 1'b1;
          end
          4'hA: begin
            res = fval + 8'h01;
            upd_z = 1'b1;
          end
          4'hB: begin
            res = fval - 8'h01;
            skip = (res == 8'h00);
          end
          4'hC: begin
            res = {s_q.mem[ADDR_STATUS][ST_C], fval[7:1]};
            alu[8] = fval[0];
            upd_c = 1'b1;
          end
          4'hD: begin
            res = {fval[6:0], s_q.mem[ADDR_STATUS][ST_C]};
            alu[8] = fval[7];
            upd_c = 1'b1;
          end
          4'hE: res = {fval[3:0], fval[7:4]};
          default: begin
            res = fval + 8'h01;
            skip = (res == 8'h00);
          end
        endcase
        // destination select for the byte group
        if (ins[11:8] > 4'h1) begin
          wr_w = !dbit;
          wr_f = dbit;
        end
      end
      2'b01: begin
        case (ins[11:10])
          2'b00: begin
            res = fval & ~(8'h01 << bsel);
            wr_f = 1'b1;
          end
          2'b01: begin
            res = fval | (8'h01 << bsel);
            wr_f = 1'b1;
          end
          2'b10: skip = !fval[bsel];
          default: skip = fval[bsel];
        endcase
      end
      2'b10: begin
        jump = 1'b1;
        jtgt = {2'b00, ins[10:0]};
      end
      default: begin
        wr_w = 1'b1;
        case (ins[11:10])
          2'b00: res = k;
          2'b01: begin
            res = k;
            jump = 1'b1;
            jtgt = s_q.stk[s_q.sp - 3'd1];
          end
          2'b10: begin
            case (ins[9:8])
              2'b00: res = s_q.w | k;
              2'b01: res = s_q.w & k;
              2'b10: res = s_q.w ^ k;
              default: wr_w = 1'b0;
            endcase
            upd_z = (ins[9:8] != 2'b11);
          end
          default: begin
            if (ins[9]) begin
              alu = mide_add(k, s_q.w, 1'b0);
            end else begin
              alu = mide_add(k, ~s_q.w, 1'b1);
            end
            res = alu[7:0];
            {upd_c, upd_dc, upd_z} = 3'b111;
          end
        endcase
      end
    endcase
    if (ins == W_RETURN || ins == W_INTERRUPT_RETURN) begin
      jump = 1'b1;
      jtgt = s_q.stk[s_q.sp - 3'd1];
    end
    if (exec) begin
      if (wr_w) begin
        s_d.w = res;
      end
      if (wr_f) begin
        s_d.mem[fa] = res;
        st = (fa == ADDR_STATUS) ? res : st;
        s_d.psc_clr = (fa == ADDR_TIMER_ZERO_COUNT) && s_q.psa;
      end
      if (upd_z) begin
        st[ST_Z] = (res == 8'h00);
      end
      if (upd_c) begin
        st[ST_C] = alu[8];
      end
      if (upd_dc) begin
        st[ST_DC] = alu[9];
      end
      if (ins == W_SLEEP) begin
        st[ST_TO] = 1'b1;
        st[ST_PD] = 1'b0;
        s_d.sleep = 1'b1;
        s_d.wdt_clr = 1'b1;
      end
      if (ins == W_WDTKICK) begin
        st[ST_TO] = 1'b1;
        st[ST_PD] = 1'b1;
        s_d.wdt_clr = 1'b1;
      end
      if (ins == W_INTERRUPT_RETURN) begin
        s_d.gie = 1'b1;
      end
      s_d.mem[ADDR_STATUS] = st;
      // the idle word falls through every decode with no effect
      s_d.pc = (ins & NOP_MASK) == NOP_VAL ? s_q.pc + 13'h0001 : jtgt;
      if (ins[13:11] == 3'b100) begin
        s_d.stk[s_q.sp] = s_q.pc + 13'h0001;
        s_d.sp = s_q.sp + 3'd1;
      end
      if (jump && ins[13:11] != 3'b100 && ins[13:11] != 3'b101) begin
        s_d.sp = s_q.sp - 3'd1;
      end
      // skip advances past the next word at once, so the idle slot never fetches it
      if (skip) begin
        s_d.pc = s_q.pc + 13'h0002;
      end
      s_d.flush = skip | jump;
    end else if (s_q.ph == MIDE_Q4) begin
      s_d.flush = 1'b0;
    end
    // register bus: address and data are taken together, one answer at a time
    aw_hit = s_q.awready && s_awvalid && s_wvalid;
    ar_hit = s_q.arready && s_arvalid;
    s_d.awready = !s_q.awready && !s_q.bvalid && s_awvalid && s_wvalid;
    s_d.wready = s_d.awready;
    s_d.arready = !s_q.arready && !s_q.rvalid && s_arvalid;
    if (s_q.bvalid && s_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (aw_hit) begin
      s_d.bvalid = 1'b1;
      s_d.rsp.bresp = RESP_OKAY;
      if (s_req.awaddr == REG_CTRL) begin
        if (s_req.wstrb[0]) begin
          s_d.run = s_req.wdata[CTRL_RUN];
          s_d.psa = s_req.wdata[CTRL_PSA];
          // a sleep word in the same slot as a wake write wins
          s_d.sleep = s_d.sleep && !(s_req.wdata[CTRL_WAKE] && !(exec && ins == W_SLEEP));
        end
      end else begin
        s_d.rsp.bresp = RESP_SLVERR;
      end
    end
    if (ar_hit) begin
      s_d.rvalid = 1'b1;
      s_d.rsp.rresp = RESP_OKAY;
      case (s_req.araddr)
        REG_CTRL: s_d.rsp.rdata = {29'h0, 1'b0, s_q.psa, s_q.run};
        REG_STATE: s_d.rsp.rdata = {9'h0, s_q.gie, s_q.sleep, s_q.pc, s_q.w};
        REG_FLAGS: s_d.rsp.rdata = {24'h0, s_q.mem[ADDR_STATUS]};
        default: begin
          s_d.rsp.rdata = 32'h0;
          s_d.rsp.rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= '0;
      s_q.mem[ADDR_STATUS] <= STATUS_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign imem_addr = s_q.pc;
  assign port_b_latch = s_q.mem[ADDR_IO_PORT_B];
  assign wdt_clear = s_q.wdt_clr;
  assign psc_clear = s_q.psc_clr;
  assign sleeping = s_q.sleep;
  assign s_awready = s_q.awready;
  assign s_wready = s_q.wready;
  assign s_bvalid = s_q.bvalid;
  assign s_arready = s_q.arready;
  assign s_rvalid = s_q.rvalid;
  assign s_rsp = s_q.rsp;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  sequence s_idle_slot;
    s_q.flush [*4] ##1 !s_q.flush;
  endsequence

  a_phase_wrap: assert property (s_q.ph == MIDE_Q4 |=> s_q.ph == MIDE_Q1)
    else $error("phase did not wrap after four clocks");
  a_skip_idle: assert property (exec && skip |=> s_idle_slot)
    else $error("skip did not give one idle slot");
  a_jump_target: assert property (exec && ins[13:11] == 3'b101 |=> s_q.pc == $past(ins[10:0]) ##0 s_idle_slot)
    else $error("jump target or idle slot wrong");
  a_call_push: assert property (exec && ins[13:11] == 3'b100 |=> s_q.sp == $past(s_q.sp) + 3'd1)
    else $error("call did not push");
  a_return_pop: assert property (exec && ins == W_RETURN |=> s_q.pc == $past(s_q.stk[s_q.sp - 3'd1]))
    else $error("return did not load stack top");
  a_kick_flags: assert property (exec && ins == W_WDTKICK |=> wdt_clear && s_q.mem[ADDR_STATUS][ST_TO]
    && s_q.mem[ADDR_STATUS][ST_PD] ##1 !wdt_clear)
    else $error("watchdog kick flags wrong");
  a_sleep_enter: assert property (exec && ins == W_SLEEP |=> sleeping && !s_q.mem[ADDR_STATUS][ST_PD])
    else $error("sleep entry wrong");
  a_add_literal_accum_sum: assert property (exec && ins[13:9] == 5'h1F |=> s_q.w == $past(s_q.w + k))
    else $error("literal add result wrong");
  a_return_with_literal_load: assert property (exec && ins[13:10] == 4'hD |=> s_q.w == $past(k) ##0 s_idle_slot)
    else $error("return with literal wrong");
  a_port_read: assert property (exec && ins[13:8] == 6'h08 && fa == ADDR_IO_PORT_B
    |=> ($past(dbit) ? port_b_latch : s_q.w) == $past(s_q.pin_s2))
    else $error("port operand not from pins");
  a_tmr_psc: assert property (exec && wr_f && fa == ADDR_TIMER_ZERO_COUNT && s_q.psa |=> psc_clear)
    else $error("prescaler not cleared");
endmodule : mide_core
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the instruction decode and execute core
`timescale 1ns/10ps
`default_nettype none
module tb;
  import mide_pkg::*;
  logic                ref_clk     = 1'b0;
  logic                reset_n     = 1'b0;
  logic [PC_W-1:0]     imem_addr;
  logic [13:0]         imem_data   = 14'h0000;
  logic [7:0]          port_b_pins = 8'hA5;
  logic [7:0]          port_b_latch;
  logic                wdt_clear;
  logic                psc_clear;
  logic                sleeping;
  logic                s_awvalid   = 1'b0;
  logic                s_wvalid    = 1'b0;
  logic                s_bready    = 1'b0;
  logic                s_arvalid   = 1'b0;
  logic                s_rready    = 1'b0;
  logic                s_awready;
  logic                s_wready;
  logic                s_bvalid;
  logic                s_arready;
  logic                s_rvalid;
  mide_axi_req_t       s_req       = '0;
  mide_axi_rsp_t       s_rsp;
  logic [13:0]         prog [16];
  logic [31:0]         st;
  logic [31:0]         fl;
  logic [1:0]          rsp;
  int                  n_errors    = 0;
  int                  checks      = 0;
  int                  n_wdt       = 0;
  int                  n_psc       = 0;

  mide_core mide_core_i (
    .ref_clk(ref_clk), .reset_n(reset_n), .imem_addr(imem_addr), .imem_data(imem_data),
    .port_b_pins(port_b_pins), .port_b_latch(port_b_latch), .wdt_clear(wdt_clear),
    .psc_clear(psc_clear), .sleeping(sleeping), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_req(s_req), .s_rsp(s_rsp)
  );

  always #4 ref_clk = ~ref_clk;

  // program memory answers the counter one clock later, well inside the four-clock stand
  always @(posedge ref_clk) begin
    imem_data <= prog[imem_addr[3:0]];
    if (!reset_n) begin
      n_wdt <= 0;
      n_psc <= 0;
    end else begin
      if (wdt_clear === 1'b1) n_wdt <= n_wdt + 1;
      if (psc_clear === 1'b1) n_psc <= n_psc + 1;
    end
  end

  task automatic close_out;
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] sv(input logic gie, input logic [12:0] pc, input logic [7:0] w);
    return {9'h000, gie, 1'b0, pc, w};
  endfunction : sv

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_awvalid    <= 1'b1;
    s_wvalid     <= 1'b1;
    s_bready     <= 1'b1;
    s_req.awaddr <= a;
    s_req.wdata  <= d;
    s_req.wstrb  <= 4'hF;
    do begin
      @(posedge ref_clk);
      if (s_awready === 1'b1) s_awvalid <= 1'b0;
      if (s_wready === 1'b1) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    rsp = s_rsp.bresp;
    s_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    s_arvalid    <= 1'b1;
    s_rready     <= 1'b1;
    s_req.araddr <= a;
    do begin
      @(posedge ref_clk);
      if (s_arready === 1'b1) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    d = s_rsp.rdata;
    rsp = s_rsp.rresp;
    s_rready <= 1'b0;
  endtask : axi_rd

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
  endtask : do_reset

  // a fresh reset per program keeps one scenario's file contents out of the next
  task automatic run_prog(input logic [13:0] p[$], input logic [31:0] ctl);
    foreach (prog[i]) prog[i] = 14'h0000;
    foreach (p[i]) prog[i] = p[i];
    do_reset;
    axi_wr(REG_CTRL, ctl);
  endtask : run_prog

  task automatic settle;
    repeat (200) @(posedge ref_clk);
    axi_rd(REG_STATE, st);
    axi_rd(REG_FLAGS, fl);
  endtask : settle

  // counts the clocks for which the counter shows one address
  task automatic stand(input logic [PC_W-1:0] a, input int exp, input string nm);
    int n;
    n = 0;
    while (imem_addr !== a) @(posedge ref_clk);
    while (imem_addr === a) begin
      n++;
      @(posedge ref_clk);
    end
    chk(nm, 32'(n), 32'(exp));
  endtask : stand

  task automatic t_regs;
    do_reset;
    axi_rd(REG_FLAGS, fl);
    chk("flags_rst", fl, 32'h0000_0018);
    axi_rd(REG_STATE, st);
    chk("state_rst", st, 32'h0000_0000);
    axi_rd(8'h0C, fl);
    chk("unmapped_rd", {fl[29:0], rsp}, {30'h0, RESP_SLVERR});
    axi_wr(8'h0C, 32'h0000_0001);
    chk("unmapped_wr", {30'h0, rsp}, {30'h0, RESP_SLVERR});
    axi_wr(REG_CTRL, 32'h0000_0006);
    chk("ctrl_wr", {30'h0, rsp}, {30'h0, RESP_OKAY});
    axi_rd(REG_CTRL, fl);
    chk("ctrl_rd", fl, 32'h0000_0002);
  endtask : t_regs

  task automatic t_lit;
    run_prog('{14'h305A, 14'h380F, 14'h0060, 14'h3AFF, 14'h0040, 14'h3930, 14'h3FE0, 14'h2807}, 32'h1);
    stand(13'd1, 4, "plain_len");
    stand(13'd2, 4, "idle_len");
    settle;
    chk("lit_state", st, sv(1'b0, 13'd7, 8'h00));
    chk("lit_flags", fl, 32'h0000_001D);
  endtask : t_lit

  task automatic t_sub;
    run_prog('{14'h3005, 14'h3D07, 14'h2802}, 32'h1);
    settle;
    chk("sub_state", st, sv(1'b0, 13'd2, 8'h02));
    chk("sub_flags", fl, 32'h0000_001B);
  endtask : t_sub

  task automatic t_rot;
    run_prog('{14'h3081, 14'h00FF, 14'h0D7F, 14'h0CFF, 14'h047F, 14'h2805}, 32'h1);
    settle;
    chk("rot_state", st, sv(1'b0, 13'd5, 8'hC2));
    chk("rot_flags", fl, 32'h0000_0019);
  endtask : t_rot

  // chains move, add, sub, and, xor, complement, swap, decrement and bit set/clear on one file location, then zero_accumulator and an add into w
  task automatic t_byte;
    run_prog('{14'h3037, 14'h00A0, 14'h3012, 14'h07A0, 14'h0220, 14'h0520, 14'h06A0, 14'h09A0,
               14'h0EA0, 14'h03A0, 14'h1320, 14'h1520, 14'h0820, 14'h0103, 14'h0720, 14'h280F}, 32'h1);
    settle;
    chk("byte_state", st, sv(1'b0, 13'd15, 8'h3E));
    chk("byte_flags", fl, 32'h0000_0018);
  endtask : t_byte

  task automatic t_skip;
    run_prog('{14'h3001, 14'h00A1, 14'h0BA1, 14'h3E40, 14'h0FA1, 14'h3E10, 14'h00A2, 14'h1E22,
               14'h3E40, 14'h1822, 14'h3E01, 14'h18A2, 14'h3E40, 14'h280D}, 32'h1);
    stand(13'd4, 8, "skip_len");
    stand(13'd5, 4, "noskip_len");
    settle;
    chk("skip_state", st, sv(1'b0, 13'd13, 8'h12));
    chk("skip_flags", fl, 32'h0000_0018);
  endtask : t_skip

  task automatic t_call;
    run_prog('{14'h2005, 14'h2007, 14'h2008, 14'h3E01, 14'h2804, 14'h3040, 14'h0008, 14'h347C,
               14'h0009}, 32'h1);
    stand(13'd5, 8, "call_len");
    settle;
    chk("call_state", st, sv(1'b1, 13'd4, 8'h7D));
  endtask : t_call

  task automatic t_sleep;
    run_prog('{14'h0063, 14'h0064, 14'h3055, 14'h2803}, 32'h1);
    settle;
    chk("sleep_pin", {31'h0, sleeping}, 32'h1);
    chk("sleep_flags", fl, 32'h0000_0010);
    chk("sleep_w", {24'h0, st[7:0]}, 32'h0);
    axi_wr(REG_CTRL, 32'h0000_0005);
    settle;
    chk("wake_state", st, sv(1'b0, 13'd3, 8'h55));
    chk("kick_flags", fl, 32'h0000_0018);
    chk("wdt_pulses", 32'(n_wdt), 32'd2);
  endtask : t_sleep

  // zero_file_reg on the timer clears the prescaler; incf with d=0 must not
  task automatic t_port;
    run_prog('{14'h30FF, 14'h0086, 14'h0886, 14'h0181, 14'h0A01, 14'h2805}, 32'h3);
    settle;
    chk("port_latch", {24'h0, port_b_latch}, 32'h0000_00A5);
    chk("psc_pulses", 32'(n_psc), 32'd1);
    chk("port_state", st, sv(1'b0, 13'd5, 8'h01));
  endtask : t_port

  initial begin
    foreach (prog[i]) prog[i] = 14'h0000;
    t_regs;
    t_lit;
    t_sub;
    t_rot;
    t_byte;
    t_skip;
    t_call;
    t_sleep;
    t_port;
    close_out;
  end

  // the whole run needs a few thousand clocks
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    close_out;
  end
endmodule : tb
`default_nettype wire
